// ---- pkg/flash_guard_defines.vh ----
// Constants for the flash region access guard
`ifndef FLASH_GUARD_DEFINES_VH
`define FLASH_GUARD_DEFINES_VH
`define FG_REGIONS       32
`define FG_REGION_BITS   5
`define FG_REGION_LSB    15
`define FG_OFF_BITS      15
`define FG_ADDR_BITS     20
`define FG_REGION_BYTES  16'h8000
`define FG_SUB_UNIT      16'h0020
`define FG_SUB_MAX_SIZE  4'hA
`define FG_SUB_ENTRIES   2
`define FG_PERM_BITS     5
`define FG_PERM_READ     0
`define FG_PERM_WRITE    1
`define FG_PERM_EXEC     2
`define FG_PERM_SECURE   3
`define FG_PERM_LOCK     4
`define FG_PERM_RESET    5'h0F
`define FG_AREA_MAIN     2'h0
`define FG_AREA_USER     2'h1
`define FG_AREA_FACTORY  2'h2
`define FG_MASTER_CPU    3'h0
`define FG_DATA_BITS     32
`endif

// ---- sim/flash_data_model.sv ----
// Flash array stand-in returning data one cycle after a request
`timescale 1ns/10ps
module flash_data_model (
  input  wire logic        clk_i,
  input  wire logic        req_valid_i,
  input  wire logic [19:0] req_addr_i,
  output logic      [31:0] flash_rdata_o
);
  initial flash_rdata_o = 32'h5A5A5A5A;
  // Data follows address; between requests the lines churn so stale data never passes
  always @(posedge clk_i) begin
    if (req_valid_i)
      flash_rdata_o <= {12'hC3A, req_addr_i};
    else
      flash_rdata_o <= ~flash_rdata_o;
  end
endmodule // flash_data_model

// ---- sim/flash_guard_monitor.sv ----
// Assertion checker for the flash region access guard
`timescale 1ns/10ps
module flash_guard_monitor (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        req_valid_i,
  input wire logic [1:0]  req_area_i,
  input wire logic        req_write_i,
  input wire logic        req_erase_i,
  input wire logic        req_fetch_i,
  input wire logic [2:0]  req_master_i,
  input wire logic        debug_active_i,
  input wire logic [31:0] flash_rdata_i,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_error_o,
  input wire logic [31:0] rsp_rdata_o,
  input wire logic        flash_read_o,
  input wire logic        secure_fault_o,
  input wire logic        bus_fault_o,
  input wire logic        flash_access_error_event_o,
  input wire logic        err_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Answers come exactly two edges after a request and never otherwise
  rsp_lat_a: assert property (req_valid_i |-> ##2 rsp_valid_o)
    else $error("answer missing");
  rsp_cause_a: assert property (rsp_valid_o |-> $past(req_valid_i, 2))
    else $error("answer without request");
  // Blocked answers must carry nothing from the array
  blk_zero_a: assert property (rsp_error_o |-> rsp_rdata_o == 32'h0 && !flash_read_o)
    else $error("blocked data leaked");
  sec_only_a: assert property (secure_fault_o |->
    rsp_error_o && !bus_fault_o && !flash_access_error_event_o) else $error("fault mix");
  bf_evt_a: assert property (bus_fault_o |-> flash_access_error_event_o && rsp_error_o)
    else $error("bus fault without event");
  cpu_fault_a: assert property ((secure_fault_o || bus_fault_o) |->
    $past(req_master_i, 2) == 3'h0) else $error("fault for other master");
  dma_evt_a: assert property (rsp_error_o && $past(req_master_i, 2) != 3'h0 |->
    flash_access_error_event_o) else $error("event missing");
  irq_evt_a: assert property (err_irq_o |-> flash_access_error_event_o)
    else $error("interrupt without event");
  // Debug state is judged in the middle stage, one edge before the answer
  cfg_fetch_a: assert property (rsp_valid_o && $past(req_fetch_i, 2) &&
    $past(req_area_i, 2) != 2'h0 && !$past(debug_active_i) |-> rsp_error_o)
    else $error("config fetch passed");
  fact_ro_a: assert property (rsp_valid_o && $past(req_area_i, 2) == 2'h2 &&
    ($past(req_write_i, 2) || $past(req_erase_i, 2)) |-> rsp_error_o) else $error("factory written");
  rd_pass_a: assert property (rsp_valid_o && !rsp_error_o && !$past(req_write_i, 2) &&
    !$past(req_erase_i, 2) |-> rsp_rdata_o == $past(flash_rdata_i)) else $error("read data lost");
endmodule // flash_guard_monitor
bind flash_region_access_guard flash_guard_monitor flash_guard_monitor_inst (.clk_i, .rstn_i,
  .req_valid_i, .req_area_i, .req_write_i, .req_erase_i, .req_fetch_i, .req_master_i,
  .debug_active_i, .flash_rdata_i, .rsp_valid_o, .rsp_error_o, .rsp_rdata_o, .flash_read_o,
  .secure_fault_o, .bus_fault_o, .flash_access_error_event_o, .err_irq_o);

// ---- sim/tb_flash_region_access_guard.sv ----
// Self-checking bench for the flash region access guard
`timescale 1ns/10ps
module tb_flash_region_access_guard;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        perm_wr_i = 1'b0;
  logic [4:0]  perm_wr_idx_i = 5'h00;
  logic [4:0]  perm_wr_data_i = 5'h00;
  logic [9:0]  callable_region_i = 10'h000;
  logic [7:0]  callable_size_i = 8'h00;
  logic [7:0]  master_secure_i = 8'h00;
  logic        err_irq_enable_i = 1'b1;
  logic        debug_active_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic [19:0] req_addr_i = 20'h00000;
  logic [1:0]  req_area_i = 2'h0;
  logic [2:0]  req_master_i = 3'h0;
  logic        req_write_i = 1'b0, req_erase_i = 1'b0, req_fetch_i = 1'b0, req_secure_i = 1'b0;
  wire  [31:0] flash_rdata_i, rsp_rdata_o;
  wire  [19:0] flash_addr_o;
  wire  [4:0]  err_region_o;
  wire  [2:0]  err_master_o;
  wire         rsp_valid_o, rsp_error_o, callable_hit_o, flash_read_o;
  wire         flash_write_o, flash_erase_o;
  wire         secure_fault_o, bus_fault_o, flash_access_error_event_o, err_irq_o;
  int          bad_count = 0, n_compared = 0, cycles = 0;

  flash_region_access_guard flash_region_access_guard_inst (.clk_i, .rstn_i, .perm_wr_i,
    .perm_wr_idx_i, .perm_wr_data_i, .callable_region_i, .callable_size_i, .master_secure_i,
    .err_irq_enable_i, .debug_active_i, .req_valid_i, .req_addr_i, .req_area_i, .req_write_i,
    .req_erase_i, .req_fetch_i, .req_master_i, .req_secure_i, .flash_rdata_i, .rsp_valid_o,
    .rsp_error_o, .rsp_rdata_o, .callable_hit_o, .flash_read_o, .flash_write_o, .flash_erase_o,
    .flash_addr_o, .secure_fault_o, .bus_fault_o, .flash_access_error_event_o, .err_irq_o,
    .err_region_o, .err_master_o);
  flash_data_model flash_data_model_inst (.clk_i, .req_valid_i, .req_addr_i,
    .flash_rdata_o(flash_rdata_i));

  // Free-running 100 MHz clock
  initial forever #5 clk_i = ~clk_i;
  // Hang guard, far above the roughly 115 cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Left high so consecutive calls write back to back
  task automatic set_perm(input logic [4:0] idx, input logic [4:0] data);
    @(negedge clk_i);
    perm_wr_i = 1'b1;
    perm_wr_idx_i = idx;
    perm_wr_data_i = data;
  endtask

  // Kind is {erase,write,fetch}; exp is {error,secure,bus,event,callable}
  task automatic xfer(input logic [19:0] a, input logic [1:0] ar, input logic [2:0] k,
                      input logic [2:0] m, input logic s, input logic [4:0] exp);
    @(negedge clk_i);
    perm_wr_i = 1'b0;
    req_valid_i = 1'b1;
    req_addr_i = a;
    req_area_i = ar;
    {req_erase_i, req_write_i, req_fetch_i} = k;
    req_master_i = m;
    req_secure_i = s;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    // Answer stands only between the second and third edge
    @(posedge clk_i);
    #1;
    chk({rsp_valid_o, rsp_error_o, secure_fault_o, bus_fault_o,
         flash_access_error_event_o, callable_hit_o}, {1'b1, exp});
    chk(err_irq_o, exp[1] & err_irq_enable_i);
    chk(rsp_rdata_o, (exp[4] | k[2] | k[1]) ? 32'h0 : {12'hC3A, a});
    chk({flash_read_o, flash_erase_o, flash_write_o, flash_addr_o},
        {~(exp[4] | k[2] | k[1]), exp[4] ? 2'h0 : k[2:1], a});
    if (exp[4] && ar == 2'h0) begin
      chk({err_region_o, err_master_o}, {a[19:15], m});
    end
    // Park on a falling edge so level inputs set next change off the sampling edge
    @(negedge clk_i);
  endtask

  task automatic test_defaults();
    xfer(20'h17FFF, 2'h0, 3'h0, 3'h0, 1'b1, 5'h00);
    xfer(20'h17FFF, 2'h0, 3'h0, 3'h0, 1'b0, 5'h18);
    xfer(20'h08000, 2'h0, 3'h2, 3'h1, 1'b1, 5'h12);
    master_secure_i = 8'h02;
    xfer(20'h08000, 2'h0, 3'h2, 3'h1, 1'b0, 5'h00);
    xfer(20'h08000, 2'h0, 3'h0, 3'h2, 1'b1, 5'h12);
    $display("test defaults done");
  endtask

  task automatic test_perms();
    set_perm(5'h03, 5'h0C);
    set_perm(5'h04, 5'h07);
    xfer(20'h18000, 2'h0, 3'h0, 3'h0, 1'b1, 5'h16);
    xfer(20'h18004, 2'h0, 3'h1, 3'h0, 1'b1, 5'h00);
    xfer(20'h18008, 2'h0, 3'h2, 3'h0, 1'b1, 5'h16);
    xfer(20'h1800C, 2'h0, 3'h4, 3'h0, 1'b1, 5'h16);
    xfer(20'h18000, 2'h0, 3'h0, 3'h0, 1'b0, 5'h18);
    xfer(20'h17FFC, 2'h0, 3'h0, 3'h0, 1'b1, 5'h00);
    xfer(20'h20000, 2'h0, 3'h0, 3'h0, 1'b0, 5'h00);
    xfer(20'h18000, 2'h0, 3'h0, 3'h1, 1'b1, 5'h12);
    err_irq_enable_i = 1'b0;
    xfer(20'h18000, 2'h0, 3'h0, 3'h0, 1'b1, 5'h16);
    err_irq_enable_i = 1'b1;
    set_perm(5'h05, 5'h19);
    set_perm(5'h05, 5'h0F);
    xfer(20'h28000, 2'h0, 3'h2, 3'h0, 1'b1, 5'h16);
    xfer(20'h28000, 2'h0, 3'h0, 3'h0, 1'b1, 5'h00);
    $display("test permissions done");
  endtask

  task automatic test_callable();
    callable_region_i = {5'h06, 5'h06};
    callable_size_i = 8'h21;
    xfer(20'h37FE0, 2'h0, 3'h1, 3'h0, 1'b0, 5'h01);
    xfer(20'h37FC0, 2'h0, 3'h1, 3'h0, 1'b0, 5'h01);
    xfer(20'h37FBC, 2'h0, 3'h1, 3'h0, 1'b0, 5'h18);
    // Oversized size clamps to half a region
    callable_size_i = 8'hF0;
    xfer(20'h34000, 2'h0, 3'h1, 3'h0, 1'b0, 5'h01);
    xfer(20'h33FFC, 2'h0, 3'h1, 3'h0, 1'b0, 5'h18);
    callable_size_i = 8'h00;
    xfer(20'h37FE0, 2'h0, 3'h1, 3'h0, 1'b0, 5'h18);
    set_perm(5'h07, 5'h07);
    callable_region_i = {5'h07, 5'h07};
    callable_size_i = 8'h33;
    xfer(20'h3FFFC, 2'h0, 3'h1, 3'h0, 1'b0, 5'h00);
    $display("test callable done");
  endtask

  task automatic test_config();
    xfer(20'h00010, 2'h1, 3'h0, 3'h0, 1'b1, 5'h00);
    xfer(20'h00010, 2'h1, 3'h2, 3'h0, 1'b1, 5'h00);
    xfer(20'h00010, 2'h1, 3'h0, 3'h0, 1'b0, 5'h18);
    xfer(20'h00010, 2'h2, 3'h2, 3'h0, 1'b1, 5'h16);
    xfer(20'h00010, 2'h2, 3'h0, 3'h0, 1'b1, 5'h00);
    // Unused area code is always refused
    xfer(20'h00010, 2'h3, 3'h0, 3'h0, 1'b1, 5'h16);
    xfer(20'h00010, 2'h1, 3'h1, 3'h0, 1'b1, 5'h16);
    debug_active_i = 1'b1;
    xfer(20'h00010, 2'h2, 3'h1, 3'h0, 1'b1, 5'h00);
    set_perm(5'h09, 5'h0B);
    xfer(20'h48000, 2'h0, 3'h1, 3'h0, 1'b1, 5'h00);
    debug_active_i = 1'b0;
    xfer(20'h48000, 2'h0, 3'h1, 3'h0, 1'b1, 5'h16);
    $display("test config done");
  endtask

  // Reset for six cycles, then run the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    test_defaults();
    test_perms();
    test_callable();
    test_config();
    stop_test();
  end
endmodule // tb_flash_region_access_guard

// ---- src/flash_region_access_guard.v ----
// Access checker between bus masters and the on-chip flash
`timescale 1ns/10ps
`include "flash_guard_defines.vh"
module flash_region_access_guard (
  input  wire                          clk_i,
  input  wire                          rstn_i,
  // Permission table programming
  input  wire                          perm_wr_i,
  input  wire [`FG_REGION_BITS-1:0]    perm_wr_idx_i,
  input  wire [`FG_PERM_BITS-1:0]      perm_wr_data_i,
  // Callable sub-region entries, packed per entry
  input  wire [2*`FG_REGION_BITS-1:0]  callable_region_i,
  input  wire [7:0]                    callable_size_i,
  // Per-master security attribute for non-CPU masters
  input  wire [7:0]                    master_secure_i,
  input  wire                          err_irq_enable_i,
  input  wire                          debug_active_i,
  // Transfer request
  input  wire                          req_valid_i,
  input  wire [`FG_ADDR_BITS-1:0]      req_addr_i,
  input  wire [1:0]                    req_area_i,
  input  wire                          req_write_i,
  input  wire                          req_erase_i,
  input  wire                          req_fetch_i,
  input  wire [2:0]                    req_master_i,
  input  wire                          req_secure_i,
  input  wire [`FG_DATA_BITS-1:0]      flash_rdata_i,
  // Answer and flash side
  output reg                           rsp_valid_o,
  output reg                           rsp_error_o,
  output reg  [`FG_DATA_BITS-1:0]      rsp_rdata_o,
  output reg                           callable_hit_o,
  output reg                           flash_read_o,
  output reg                           flash_write_o,
  output reg                           flash_erase_o,
  output reg  [`FG_ADDR_BITS-1:0]      flash_addr_o,
  output reg                           secure_fault_o,
  output reg                           bus_fault_o,
  output reg                           flash_access_error_event_o,
  output reg                           err_irq_o,
  output reg  [`FG_REGION_BITS-1:0]    err_region_o,
  output reg  [2:0]                    err_master_o
);
  // Stage one registers, aligned with the permission read
  reg                          s1_valid_reg;
  reg  [`FG_ADDR_BITS-1:0]     s1_addr_reg;
  reg  [1:0]                   s1_area_reg;
  reg                          s1_write_reg;
  reg                          s1_erase_reg;
  reg                          s1_fetch_reg;
  reg                          s1_cpu_reg;
  reg                          s1_secure_reg;
  reg  [2:0]                   s1_master_reg;
  wire [`FG_PERM_BITS-1:0]     perm;
  wire [`FG_REGION_BITS-1:0]   req_region;
  wire [`FG_REGION_BITS-1:0]   s1_region;
  wire [`FG_OFF_BITS-1:0]      s1_offset;
  wire                         req_cpu;
  wire                         req_attr;
  wire [4*`FG_SUB_ENTRIES-1:0] sub_eff;
  reg  [3:0]                   sub_size;
  reg  [15:0]                  sub_low;
  reg                          in_sub;
  reg                          sec_required;
  reg                          sec_viol;
  reg                          perm_viol;
  reg                          blocked;
  reg                          s2_error_next;
  reg                          sfault_next;
  reg                          bfault_next;
  reg                          event_next;
  integer                      k;
  genvar                       g;

  // Region index is the offset divided by the region size
  assign req_region = req_addr_i[`FG_ADDR_BITS-1:`FG_REGION_LSB];
  assign s1_region  = s1_addr_reg[`FG_ADDR_BITS-1:`FG_REGION_LSB];
  assign s1_offset  = s1_addr_reg[`FG_OFF_BITS-1:0];
  assign req_cpu    = (req_master_i == `FG_MASTER_CPU);

  // Non-CPU masters cannot vouch for themselves; use the table here
  assign req_attr = req_cpu ? req_secure_i : master_secure_i[req_master_i];

  region_perm_table u_perm (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .wr_i      (perm_wr_i),
    .wr_idx_i  (perm_wr_idx_i),
    .wr_data_i (perm_wr_data_i),
    .rd_idx_i  (req_region),
    .rd_data_o (perm)
  );

  // Capture the request while the table is read
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_valid_reg  <= 1'b0;
      s1_addr_reg   <= {`FG_ADDR_BITS{1'b0}};
      s1_area_reg   <= `FG_AREA_MAIN;
      s1_write_reg  <= 1'b0;
      s1_erase_reg  <= 1'b0;
      s1_fetch_reg  <= 1'b0;
      s1_cpu_reg    <= 1'b0;
      s1_secure_reg <= 1'b0;
      s1_master_reg <= 3'h0;
    end else begin
      s1_valid_reg  <= req_valid_i;
      s1_addr_reg   <= req_addr_i;
      s1_area_reg   <= req_area_i;
      s1_write_reg  <= req_write_i;
      s1_erase_reg  <= req_erase_i;
      s1_fetch_reg  <= req_fetch_i;
      s1_cpu_reg    <= req_cpu;
      s1_secure_reg <= req_attr;
      s1_master_reg <= req_master_i;
    end
  end

  // Per entry: size counts only if nonzero and aimed at this region
  generate
    for (g = 0; g < `FG_SUB_ENTRIES; g = g + 1) begin : g_sub
      wire [3:0] sz  = callable_size_i[g*4 +: 4];
      wire [3:0] cap = (sz > `FG_SUB_MAX_SIZE) ? `FG_SUB_MAX_SIZE : sz;
      wire       sel = (callable_region_i[g*`FG_REGION_BITS +: `FG_REGION_BITS] == s1_region);
      assign sub_eff[g*4 +: 4] = sel ? cap : 4'h0;
    end
  endgenerate

  // Largest matching size wins; sub-region only inside a secure region
  always @* begin
    sub_size = 4'h0;
    for (k = 0; k < `FG_SUB_ENTRIES; k = k + 1) begin
      if (sub_eff[k*4 +: 4] > sub_size) begin
        sub_size = sub_eff[k*4 +: 4];
      end
    end
    // Size n spans 32 bytes shifted up by n-1, counted down from the top
    sub_low = `FG_REGION_BYTES - (`FG_SUB_UNIT << (sub_size - 4'h1));
    in_sub  = (s1_area_reg == `FG_AREA_MAIN) && (sub_size != 4'h0) &&
              perm[`FG_PERM_SECURE] && ({1'b0, s1_offset} >= sub_low);
  end

  // Violation classification
  always @* begin
    sec_required = 1'b0;
    perm_viol    = 1'b0;
    case (s1_area_reg)
      `FG_AREA_MAIN: begin
        sec_required = perm[`FG_PERM_SECURE];
        if (s1_fetch_reg) begin
          perm_viol = !perm[`FG_PERM_EXEC] && !debug_active_i;
        end else if (s1_write_reg || s1_erase_reg) begin
          perm_viol = !perm[`FG_PERM_WRITE];
        end else begin
          perm_viol = !perm[`FG_PERM_READ];
        end
      end
      `FG_AREA_USER: begin
        sec_required = 1'b1;
        perm_viol    = s1_fetch_reg && !debug_active_i;
      end
      `FG_AREA_FACTORY: begin
        sec_required = 1'b1;
        perm_viol    = (s1_fetch_reg && !debug_active_i) ||
                       s1_write_reg || s1_erase_reg;
      end
      default: begin
        sec_required = 1'b1;
        perm_viol    = 1'b1;
      end
    endcase
    // A non-secure CPU fetch into the callable top is the legal entry path
    sec_viol = sec_required && !s1_secure_reg &&
               !(in_sub && s1_fetch_reg && s1_cpu_reg);
    blocked  = sec_viol || perm_viol;
  end

  // Fault and event routing by master type
  always @* begin
    s2_error_next = s1_valid_reg && blocked;
    sfault_next   = 1'b0;
    bfault_next   = 1'b0;
    event_next    = 1'b0;
    if (s1_valid_reg && s1_cpu_reg) begin
      sfault_next = sec_viol;
      bfault_next = !sec_viol && perm_viol;
      event_next  = !sec_viol && perm_viol;
    end else if (s1_valid_reg) begin
      event_next  = blocked;
    end
  end

  // Answer stage, every output straight from a flip-flop
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_o                <= 1'b0;
      rsp_error_o                <= 1'b0;
      rsp_rdata_o                <= {`FG_DATA_BITS{1'b0}};
      callable_hit_o             <= 1'b0;
      flash_read_o               <= 1'b0;
      flash_write_o              <= 1'b0;
      flash_erase_o              <= 1'b0;
      flash_addr_o               <= {`FG_ADDR_BITS{1'b0}};
      secure_fault_o             <= 1'b0;
      bus_fault_o                <= 1'b0;
      flash_access_error_event_o <= 1'b0;
      err_irq_o                  <= 1'b0;
    end else begin
      rsp_valid_o <= s1_valid_reg;
      rsp_error_o <= s2_error_next;
      // Zero data hides blocked content from the master
      if (s1_valid_reg && !blocked && !s1_write_reg && !s1_erase_reg) begin
        rsp_rdata_o <= flash_rdata_i;
      end else begin
        rsp_rdata_o <= {`FG_DATA_BITS{1'b0}};
      end
      callable_hit_o <= s1_valid_reg && in_sub;
      flash_read_o  <= s1_valid_reg && !blocked && !s1_write_reg && !s1_erase_reg;
      // Blocked writes and erases never reach the array
      flash_write_o <= s1_valid_reg && !blocked && s1_write_reg;
      flash_erase_o <= s1_valid_reg && !blocked && s1_erase_reg;
      flash_addr_o  <= s1_addr_reg;
      secure_fault_o             <= sfault_next;
      bus_fault_o                <= bfault_next;
      flash_access_error_event_o <= event_next;
      err_irq_o                  <= event_next && err_irq_enable_i;
    end
  end

  // Where the last blocked transfer went, for fault handlers
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_region_o <= {`FG_REGION_BITS{1'b0}};
      err_master_o <= 3'h0;
    end else if (s2_error_next) begin
      err_region_o <= s1_region;
      err_master_o <= s1_master_reg;
    end
  end
endmodule // flash_region_access_guard

// ---- src/region_perm_table.v ----
// Table of per-region permission sets with lockable entries
`timescale 1ns/10ps
`include "flash_guard_defines.vh"
module region_perm_table (
  input  wire                         clk_i,
  input  wire                         rstn_i,
  input  wire                         wr_i,
  input  wire [`FG_REGION_BITS-1:0]   wr_idx_i,
  input  wire [`FG_PERM_BITS-1:0]     wr_data_i,
  input  wire [`FG_REGION_BITS-1:0]   rd_idx_i,
  output reg  [`FG_PERM_BITS-1:0]     rd_data_o
);
  wire [`FG_PERM_BITS*`FG_REGIONS-1:0] flat;
  genvar g;

  // One entry per region, each written on its own
  generate
    for (g = 0; g < `FG_REGIONS; g = g + 1) begin : g_entry
      reg [`FG_PERM_BITS-1:0] perm_reg;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          perm_reg <= `FG_PERM_RESET;
        end else if (wr_i && (wr_idx_i == g) && !perm_reg[`FG_PERM_LOCK]) begin
          perm_reg <= wr_data_i;
        end
      end
      assign flat[g*`FG_PERM_BITS +: `FG_PERM_BITS] = perm_reg;
    end
  endgenerate

  // Registered read port, one cycle of latency
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= {`FG_PERM_BITS{1'b0}};
    end else begin
      rd_data_o <= flat[rd_idx_i*`FG_PERM_BITS +: `FG_PERM_BITS];
    end
  end
endmodule // region_perm_table
